// file: core/ddrsr_ctl.sv
// Memory controller end: init, bank open, burst issue, self refresh entry and exit
`include "ddrsr_defs.svh"
module ddrsr_ctl (
   input wire logic clk_sys,
   input wire logic rst,
   ddrsr_if.ctl bus,
   input wire logic req_valid,
   input wire logic req_write,
   input wire logic [1:0] req_bank,
   input wire logic [12:0] req_row,
   input wire logic [9:0] req_col,
   input wire logic [127:0] req_wdata,
   output logic req_ready,
   output logic rd_valid,
   output logic [127:0] rd_data,
   input wire logic sr_req,
   output logic sr_active,
   input wire logic term_req
);
   // ----------------------------------------
   // Derived constants
   // ----------------------------------------
   localparam logic [7:0] TOFF = 8'(`DDRSR_TOFF_CYC);
   localparam logic [7:0] XRD = 8'(`DDRSR_XRD_CYC);
   localparam logic [7:0] XNR = 8'(`DDRSR_XNR_CYC);
   localparam logic [7:0] RCD = 8'(`DDRSR_RCD_CYC);
   localparam logic [7:0] RP = 8'(`DDRSR_RP_CYC);
   localparam logic [3:0] RLAT = {1'b0, `DDRSR_CFG_ADD} + {1'b0, `DDRSR_CFG_CAS};
   localparam logic [3:0] HI = RLAT - 4'h2;
   localparam logic [1:0] CLKS = `DDRSR_CFG_BURST8 ? 2'h3 : 2'h1;
   localparam logic [4:0] DRAIN = {1'b0, RLAT} + {3'h0, CLKS} + 5'h02;

   ddrsr_pkg::ddrsr_cst_t st_r, st_nxt;
   ddrsr_pkg::ddrsr_cmd_t cmd_r, cmd_nxt;
   logic [1:0] bank_r, bank_nxt;
   logic [12:0] addr_r, addr_nxt;
   logic odt_r, odt_nxt, lastw_r, lastw_nxt, push;
   logic [3:0] open_r, open_nxt;
   logic [3:0][12:0] row_r, row_nxt;
   logic [7:0] wait_r, wait_nxt, xcnt_r, xcnt_nxt;
   logic [1:0] gap_r, gap_nxt;
   logic [4:0] drain_r, drain_nxt;

   // ----------------------------------------
   // Command sequencer
   // ----------------------------------------
   always_comb begin
      st_nxt = st_r;
      cmd_nxt = ddrsr_pkg::CMD_NOP;
      bank_nxt = bank_r;
      addr_nxt = addr_r;
      lastw_nxt = lastw_r;
      open_nxt = open_r;
      row_nxt = row_r;
      req_ready = 1'b0;
      push = 1'b0;
      wait_nxt = (wait_r != 8'h00) ? wait_r - 8'h01 : 8'h00;
      gap_nxt = (gap_r != 2'h0) ? gap_r - 2'h1 : 2'h0;
      drain_nxt = (drain_r != 5'h00) ? drain_r - 5'h01 : 5'h00;
      xcnt_nxt = (xcnt_r == XRD) ? xcnt_r : xcnt_r + 8'h01;
      case (st_r)
         ddrsr_pkg::C_MODE: begin
            cmd_nxt = ddrsr_pkg::CMD_MODE;
            addr_nxt = 13'h0000;
            addr_nxt[`DDRSR_MR_BURST_LSB +: 3] = `DDRSR_CFG_BURST8 ? `DDRSR_BURST8_CODE : `DDRSR_BURST4_CODE;
            addr_nxt[`DDRSR_MR_CAS_LSB +: 3] = `DDRSR_CFG_CAS;
            st_nxt = ddrsr_pkg::C_EXT;
         end
         ddrsr_pkg::C_EXT: begin
            cmd_nxt = ddrsr_pkg::CMD_EXT_MODE;
            addr_nxt = 13'h0000;
            addr_nxt[`DDRSR_EMR_ADD_LSB +: 3] = `DDRSR_CFG_ADD;
            addr_nxt[`DDRSR_EMR_SE_BIT] = !`DDRSR_CFG_DIFF;
            st_nxt = ddrsr_pkg::C_RUN;
         end
         ddrsr_pkg::C_RUN: begin
            if (wait_r != 8'h00) begin
               st_nxt = st_r;
            end else if (sr_req) begin
               // Data in flight must drain before the banks are closed
               if (drain_r == 5'h00 && xcnt_r >= XNR) begin
                  if (|open_r) begin
                     cmd_nxt = ddrsr_pkg::CMD_PRE_ALL;
                     open_nxt = 4'h0;
                     wait_nxt = RP;
                  end else begin
                     st_nxt = ddrsr_pkg::C_TOFF;
                     wait_nxt = TOFF;
                  end
               end
            end else if (req_valid) begin
               if (!open_r[req_bank]) begin
                  if (xcnt_r >= XNR) begin
                     cmd_nxt = ddrsr_pkg::CMD_ACT;
                     bank_nxt = req_bank;
                     addr_nxt = req_row;
                     open_nxt[req_bank] = 1'b1;
                     row_nxt[req_bank] = req_row;
                     wait_nxt = RCD;
                  end
               end else if (row_r[req_bank] != req_row) begin
                  // Row miss closes every bank; simple, at some cost in bandwidth
                  if (drain_r == 5'h00 && xcnt_r >= XNR) begin
                     cmd_nxt = ddrsr_pkg::CMD_PRE_ALL;
                     open_nxt = 4'h0;
                     wait_nxt = RP;
                  end
               end else if (gap_r == 2'h0 && (req_write == lastw_r || drain_r == 5'h00)
                            && xcnt_r >= (req_write ? XNR : XRD)) begin
                  req_ready = 1'b1;
                  cmd_nxt = req_write ? ddrsr_pkg::CMD_WR : ddrsr_pkg::CMD_RD;
                  bank_nxt = req_bank;
                  addr_nxt = {3'h0, req_col};
                  gap_nxt = CLKS;
                  drain_nxt = DRAIN;
                  lastw_nxt = req_write;
                  push = req_write;
               end
            end
         end
         ddrsr_pkg::C_TOFF: begin
            if (wait_r == 8'h00) begin
               cmd_nxt = ddrsr_pkg::CMD_SR_ENTER;
               st_nxt = ddrsr_pkg::C_SELF;
            end
         end
         ddrsr_pkg::C_SELF: begin
            if (!sr_req) begin
               cmd_nxt = ddrsr_pkg::CMD_SR_EXIT;
               st_nxt = ddrsr_pkg::C_RUN;
               xcnt_nxt = 8'h00;
            end
         end
         default: st_nxt = ddrsr_pkg::C_MODE;
      endcase
      // Current count, not next: termination first comes on in the very clock the device check allows
      odt_nxt = term_req && st_nxt == ddrsr_pkg::C_RUN && st_r == ddrsr_pkg::C_RUN && xcnt_r >= XRD;
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         st_r <= ddrsr_pkg::C_MODE;
         cmd_r <= ddrsr_pkg::CMD_NOP;
         bank_r <= 2'h0;
         addr_r <= 13'h0000;
         odt_r <= 1'b0;
         lastw_r <= 1'b0;
         open_r <= 4'h0;
         row_r <= '0;
         wait_r <= 8'h00;
         xcnt_r <= XRD;
         gap_r <= 2'h0;
         drain_r <= 5'h00;
      end else begin
         st_r <= st_nxt;
         cmd_r <= cmd_nxt;
         bank_r <= bank_nxt;
         addr_r <= addr_nxt;
         odt_r <= odt_nxt;
         lastw_r <= lastw_nxt;
         open_r <= open_nxt;
         row_r <= row_nxt;
         wait_r <= wait_nxt;
         xcnt_r <= xcnt_nxt;
         gap_r <= gap_nxt;
         drain_r <= drain_nxt;
      end
   end

   // ----------------------------------------
   // Write data pipe and drive
   // ----------------------------------------
   logic [15:0] wv_r, wv_nxt;
   logic [15:0][127:0] wd_r, wd_nxt;
   logic [127:0] wsh_r, wsh_nxt;
   logic [1:0] wleft_r, wleft_nxt;
   logic [31:0] dq_r, dq_nxt;
   logic dq_oe_r, dq_oe_nxt;

   always_comb begin
      wv_nxt = {wv_r[14:0], push};
      wd_nxt = {wd_r[14:0], req_wdata};
      wsh_nxt = wsh_r;
      wleft_nxt = wleft_r;
      dq_nxt = dq_r;
      dq_oe_nxt = 1'b0;
      if (wv_r[HI]) begin
         // Registered one clock ahead so beats land at write latency
         dq_nxt = wd_r[HI][31:0];
         wsh_nxt = {32'h0, wd_r[HI][127:32]};
         wleft_nxt = CLKS;
         dq_oe_nxt = 1'b1;
      end else if (wleft_r != 2'h0) begin
         dq_nxt = wsh_r[31:0];
         wsh_nxt = {32'h0, wsh_r[127:32]};
         wleft_nxt = wleft_r - 2'h1;
         dq_oe_nxt = 1'b1;
      end
   end

   // ----------------------------------------
   // Read capture, qualified by the strobe
   // ----------------------------------------
   logic [1:0] rcnt_r, rcnt_nxt;
   logic [127:0] rbuf_r, rbuf_nxt, rdat_r, rdat_nxt;
   logic rv_r, rv_nxt, qual;

   // Own write strobes are ignored so writes never look like reads
   assign qual = bus.dqs & (!`DDRSR_CFG_DIFF | ~bus.dqs_n) & ~dq_oe_r;

   always_comb begin
      rcnt_nxt = rcnt_r;
      rbuf_nxt = rbuf_r;
      rdat_nxt = rdat_r;
      rv_nxt = 1'b0;
      if (qual) begin
         rbuf_nxt[{rcnt_r, 5'h00} +: 32] = bus.dq;
         if (rcnt_r == CLKS) begin
            rdat_nxt = rbuf_nxt;
            rv_nxt = 1'b1;
            rcnt_nxt = 2'h0;
         end else begin
            rcnt_nxt = rcnt_r + 2'h1;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         wv_r <= 16'h0000;
         wd_r <= '0;
         wsh_r <= 128'h0;
         wleft_r <= 2'h0;
         dq_r <= 32'h0;
         dq_oe_r <= 1'b0;
         rcnt_r <= 2'h0;
         rbuf_r <= 128'h0;
         rdat_r <= 128'h0;
         rv_r <= 1'b0;
      end else begin
         wv_r <= wv_nxt;
         wd_r <= wd_nxt;
         wsh_r <= wsh_nxt;
         wleft_r <= wleft_nxt;
         dq_r <= dq_nxt;
         dq_oe_r <= dq_oe_nxt;
         rcnt_r <= rcnt_nxt;
         rbuf_r <= rbuf_nxt;
         rdat_r <= rdat_nxt;
         rv_r <= rv_nxt;
      end
   end

   assign bus.cmd = cmd_r;
   assign bus.bank = bank_r;
   assign bus.addr = addr_r;
   assign bus.on_die_termination = odt_r;
   assign bus.ctl_dq_o = dq_r;
   assign bus.ctl_dq_oe = dq_oe_r;
   assign bus.ctl_dqs_o = dq_oe_r;
   assign bus.ctl_dqs_oe = dq_oe_r;
   assign bus.ctl_dqs_n_o = 1'b0;
   assign bus.ctl_dqs_n_oe = dq_oe_r & `DDRSR_CFG_DIFF;
   assign rd_valid = rv_r;
   assign rd_data = rdat_r;
   assign sr_active = st_r == ddrsr_pkg::C_SELF;
endmodule : ddrsr_ctl

// file: core/ddrsr_defs.svh
// Shared offsets, fields, reset values and timing counts for the DDR2 link model
`ifndef DDRSR_DEFS_SVH
`define DDRSR_DEFS_SVH
// ----------------------------------------
// Clock and time-to-cycle rounding (least times round up)
// ----------------------------------------
`define DDRSR_CLK_NS 20
`define DDRSR_CYC_UP(ns) (((ns) + `DDRSR_CLK_NS - 1) / `DDRSR_CLK_NS)
`define DDRSR_TOFF_NS 60
`define DDRSR_XRD_NS 4000
`define DDRSR_XNR_NS 200
`define DDRSR_RCD_NS 40
`define DDRSR_RP_NS 40
`define DDRSR_TOFF_CYC `DDRSR_CYC_UP(`DDRSR_TOFF_NS)
`define DDRSR_XRD_CYC `DDRSR_CYC_UP(`DDRSR_XRD_NS)
`define DDRSR_XNR_CYC `DDRSR_CYC_UP(`DDRSR_XNR_NS)
`define DDRSR_RCD_CYC `DDRSR_CYC_UP(`DDRSR_RCD_NS)
`define DDRSR_RP_CYC `DDRSR_CYC_UP(`DDRSR_RP_NS)
// ----------------------------------------
// Mode word fields on the address lines
// ----------------------------------------
`define DDRSR_MR_BURST_LSB 0
`define DDRSR_MR_CAS_LSB 4
`define DDRSR_EMR_ADD_LSB 3
`define DDRSR_EMR_SE_BIT 10
`define DDRSR_BURST4_CODE 3'h2
`define DDRSR_BURST8_CODE 3'h3
// ----------------------------------------
// Reset values and controller configuration
// ----------------------------------------
`define DDRSR_RST_CAS 3'h3
`define DDRSR_RST_ADD 3'h0
`define DDRSR_RST_DIFF 1'b1
`define DDRSR_CFG_CAS 3'h3
`define DDRSR_CFG_ADD 3'h2
`define DDRSR_CFG_BURST8 1'b0
`define DDRSR_CFG_DIFF 1'b1
`endif

// file: core/ddrsr_pkg.sv
// Types shared by both ends of the DDR2 link model
package ddrsr_pkg;
   typedef enum logic [3:0] {
      CMD_NOP = 4'h0,
      CMD_ACT = 4'h1,
      CMD_RD = 4'h2,
      CMD_WR = 4'h3,
      CMD_PRE_ALL = 4'h4,
      CMD_MODE = 4'h5,
      CMD_EXT_MODE = 4'h6,
      CMD_SR_ENTER = 4'h7,
      CMD_SR_EXIT = 4'h8
   } ddrsr_cmd_t;
   typedef enum logic [1:0] {D_RUN = 2'b01, D_SELF = 2'b10} ddrsr_dst_t;
   typedef enum logic [4:0] {
      C_MODE = 5'b00001,
      C_EXT = 5'b00010,
      C_RUN = 5'b00100,
      C_TOFF = 5'b01000,
      C_SELF = 5'b10000
   } ddrsr_cst_t;
endpackage : ddrsr_pkg

// file: core/ddrsr_if.sv
// Link between the memory controller end and the memory device end
interface ddrsr_if;
   ddrsr_pkg::ddrsr_cmd_t cmd;
   logic [1:0] bank;
   logic [12:0] addr;
   logic on_die_termination;
   logic [31:0] ctl_dq_o;
   logic ctl_dq_oe;
   logic ctl_dqs_o;
   logic ctl_dqs_oe;
   logic ctl_dqs_n_o;
   logic ctl_dqs_n_oe;
   logic [31:0] dev_dq_o;
   logic dev_dq_oe;
   logic dev_dqs_o;
   logic dev_dqs_oe;
   logic dev_dqs_n_o;
   logic dev_dqs_n_oe;
   logic [31:0] dq;
   logic dqs;
   logic dqs_n;
   // ----------------------------------------
   // Wire resolution; undriven lines read low
   // ----------------------------------------
   assign dq = dev_dq_oe ? dev_dq_o : (ctl_dq_oe ? ctl_dq_o : 32'h0);
   assign dqs = dev_dqs_oe ? dev_dqs_o : (ctl_dqs_oe ? ctl_dqs_o : 1'b0);
   assign dqs_n = dev_dqs_n_oe ? dev_dqs_n_o : (ctl_dqs_n_oe ? ctl_dqs_n_o : 1'b0);
   modport ctl (
      output cmd, bank, addr, on_die_termination,
      output ctl_dq_o, ctl_dq_oe, ctl_dqs_o, ctl_dqs_oe, ctl_dqs_n_o, ctl_dqs_n_oe,
      input dq, dqs, dqs_n
   );
   modport dev (
      input cmd, bank, addr, on_die_termination, dq, dqs, dqs_n,
      output dev_dq_o, dev_dq_oe, dev_dqs_o, dev_dqs_oe, dev_dqs_n_o, dev_dqs_n_oe
   );
endinterface : ddrsr_if

// file: core/ddrsr_dev.sv
// Memory device end: command decode, latency pipe, burst engine, self refresh
`include "ddrsr_defs.svh"
module ddrsr_dev (
   input wire logic clk_sys,
   input wire logic rst,
   ddrsr_if.dev bus,
   output logic self_refresh,
   output logic term_on,
   output logic cmd_error,
   output logic strobe_diff,
   output logic [3:0] read_latency,
   output logic [3:0] write_latency
);
   localparam logic [7:0] TOFF = 8'(`DDRSR_TOFF_CYC);
   localparam logic [7:0] XRD = 8'(`DDRSR_XRD_CYC);
   localparam logic [7:0] XNR = 8'(`DDRSR_XNR_CYC);
   ddrsr_pkg::ddrsr_dst_t st_r, st_nxt;
   logic [3:0] open_r, open_nxt;
   logic [2:0] cas_r, cas_nxt, add_r, add_nxt;
   logic burst8_r, burst8_nxt, diff_r, diff_nxt, err_r, err_nxt, term_r, term_nxt;
   logic [7:0] xcnt_r, xcnt_nxt, tcnt_r, tcnt_nxt;
   logic [15:0] pv_r, pv_nxt, pw_r, pw_nxt;
   logic [15:0][5:0] pa_r, pa_nxt;
   logic [1:0] rleft_r, rleft_nxt, wleft_r, wleft_nxt;
   logic [2:0] rk_r, rk_nxt, wk_r, wk_nxt;
   logic [5:0] ra_r, ra_nxt, wa_r, wa_nxt;
   logic [31:0] dq_r, dq_nxt;
   logic dq_oe_r, dq_oe_nxt;
   logic [15:0] mem_r [0:63];
   logic wen, ok, qual;
   logic [5:0] wi0, wi1;
   logic [3:0] rlat, hi;
   logic [1:0] clks;

   // ----------------------------------------
   // Beat address: wraps inside the burst, so beats never leave the aligned burst block
   // ----------------------------------------
   function automatic logic [5:0] beat_idx(input logic [5:0] a, input logic [2:0] k, input logic b8);
      beat_idx = b8 ? {a[5:3], a[2:0] + k} : {a[5:2], a[1:0] + k[1:0]};
   endfunction : beat_idx

   assign rlat = {1'b0, add_r} + {1'b0, cas_r};
   assign hi = rlat - 4'h2;
   assign clks = burst8_r ? 2'h3 : 2'h1;
   assign qual = bus.dqs & (~diff_r | ~bus.dqs_n);

   // ----------------------------------------
   // Command decode and timing checks
   // ----------------------------------------
   always_comb begin
      st_nxt = st_r;
      open_nxt = open_r;
      cas_nxt = cas_r;
      add_nxt = add_r;
      burst8_nxt = burst8_r;
      diff_nxt = diff_r;
      err_nxt = 1'b0;
      ok = 1'b0;
      xcnt_nxt = (xcnt_r == XRD) ? xcnt_r : xcnt_r + 8'h01;
      tcnt_nxt = bus.on_die_termination ? 8'h00 : ((tcnt_r == TOFF) ? tcnt_r : tcnt_r + 8'h01);
      term_nxt = bus.on_die_termination && (st_r == ddrsr_pkg::D_RUN);
      case (st_r)
         ddrsr_pkg::D_RUN: begin
            if (bus.on_die_termination && xcnt_r < XRD) err_nxt = 1'b1;
            if (bus.cmd != ddrsr_pkg::CMD_NOP && bus.cmd != ddrsr_pkg::CMD_RD && xcnt_r < XNR) begin
               err_nxt = 1'b1;
            end
            case (bus.cmd)
               ddrsr_pkg::CMD_ACT: open_nxt[bus.bank] = 1'b1;
               ddrsr_pkg::CMD_RD: begin
                  ok = open_r[bus.bank] && xcnt_r >= XRD;
                  err_nxt = !ok;
               end
               ddrsr_pkg::CMD_WR: begin
                  ok = open_r[bus.bank] && xcnt_r >= XNR;
                  err_nxt = !ok;
               end
               ddrsr_pkg::CMD_PRE_ALL: open_nxt = 4'h0;
               ddrsr_pkg::CMD_MODE: begin
                  cas_nxt = bus.addr[`DDRSR_MR_CAS_LSB +: 3];
                  burst8_nxt = bus.addr[`DDRSR_MR_BURST_LSB +: 3] == `DDRSR_BURST8_CODE;
               end
               ddrsr_pkg::CMD_EXT_MODE: begin
                  add_nxt = bus.addr[`DDRSR_EMR_ADD_LSB +: 3];
                  diff_nxt = !bus.addr[`DDRSR_EMR_SE_BIT];
               end
               ddrsr_pkg::CMD_SR_ENTER: begin
                  if (|open_r || tcnt_r < TOFF || bus.on_die_termination) err_nxt = 1'b1;
                  st_nxt = ddrsr_pkg::D_SELF;
               end
               ddrsr_pkg::CMD_SR_EXIT: err_nxt = 1'b1;
               default: ;
            endcase
         end
         ddrsr_pkg::D_SELF: begin
            if (bus.cmd == ddrsr_pkg::CMD_SR_EXIT) begin
               st_nxt = ddrsr_pkg::D_RUN;
               xcnt_nxt = 8'h00;
            end else if (bus.cmd != ddrsr_pkg::CMD_NOP || bus.on_die_termination) begin
               err_nxt = 1'b1;
            end
         end
         default: st_nxt = ddrsr_pkg::D_RUN;
      endcase
      pv_nxt = {pv_r[14:0], ok};
      pw_nxt = {pw_r[14:0], bus.cmd == ddrsr_pkg::CMD_WR};
      pa_nxt = {pa_r[14:0], {bus.bank, bus.addr[3:0]}};
   end

   // ----------------------------------------
   // Burst engines, two beats per clock
   // ----------------------------------------
   always_comb begin
      dq_nxt = dq_r;
      dq_oe_nxt = 1'b0;
      ra_nxt = ra_r;
      rk_nxt = rk_r;
      rleft_nxt = rleft_r;
      wa_nxt = wa_r;
      wk_nxt = wk_r;
      wleft_nxt = wleft_r;
      wen = 1'b0;
      wi0 = 6'h00;
      wi1 = 6'h00;
      if (pv_r[hi] && !pw_r[hi]) begin
         // Registered here so the first beats sit on the lines at read latency
         ra_nxt = pa_r[hi];
         dq_nxt = {mem_r[beat_idx(pa_r[hi], 3'h1, burst8_r)], mem_r[beat_idx(pa_r[hi], 3'h0, burst8_r)]};
         rk_nxt = 3'h2;
         rleft_nxt = clks;
         dq_oe_nxt = 1'b1;
      end else if (rleft_r != 2'h0) begin
         dq_nxt = {mem_r[beat_idx(ra_r, rk_r + 3'h1, burst8_r)], mem_r[beat_idx(ra_r, rk_r, burst8_r)]};
         rk_nxt = rk_r + 3'h2;
         rleft_nxt = rleft_r - 2'h1;
         dq_oe_nxt = 1'b1;
      end
      if (pv_r[hi] && pw_r[hi]) begin
         // Write latency is one clock under read latency
         wa_nxt = pa_r[hi];
         wi0 = beat_idx(pa_r[hi], 3'h0, burst8_r);
         wi1 = beat_idx(pa_r[hi], 3'h1, burst8_r);
         wen = qual;
         wk_nxt = 3'h2;
         wleft_nxt = clks;
      end else if (wleft_r != 2'h0) begin
         wi0 = beat_idx(wa_r, wk_r, burst8_r);
         wi1 = beat_idx(wa_r, wk_r + 3'h1, burst8_r);
         wen = qual;
         wk_nxt = wk_r + 3'h2;
         wleft_nxt = wleft_r - 2'h1;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         st_r <= ddrsr_pkg::D_RUN;
         open_r <= 4'h0;
         cas_r <= `DDRSR_RST_CAS;
         add_r <= `DDRSR_RST_ADD;
         burst8_r <= 1'b0;
         diff_r <= `DDRSR_RST_DIFF;
         err_r <= 1'b0;
         term_r <= 1'b0;
         xcnt_r <= XRD;
         tcnt_r <= TOFF;
         pv_r <= 16'h0000;
         pw_r <= 16'h0000;
         pa_r <= '0;
         rleft_r <= 2'h0;
         wleft_r <= 2'h0;
         rk_r <= 3'h0;
         wk_r <= 3'h0;
         ra_r <= 6'h00;
         wa_r <= 6'h00;
         dq_r <= 32'h0;
         dq_oe_r <= 1'b0;
      end else begin
         st_r <= st_nxt;
         open_r <= open_nxt;
         cas_r <= cas_nxt;
         add_r <= add_nxt;
         burst8_r <= burst8_nxt;
         diff_r <= diff_nxt;
         err_r <= err_nxt;
         term_r <= term_nxt;
         xcnt_r <= xcnt_nxt;
         tcnt_r <= tcnt_nxt;
         pv_r <= pv_nxt;
         pw_r <= pw_nxt;
         pa_r <= pa_nxt;
         rleft_r <= rleft_nxt;
         wleft_r <= wleft_nxt;
         rk_r <= rk_nxt;
         wk_r <= wk_nxt;
         ra_r <= ra_nxt;
         wa_r <= wa_nxt;
         dq_r <= dq_nxt;
         dq_oe_r <= dq_oe_nxt;
      end
   end

   // Array holds no reset; contents are unknown until written
   always_ff @(posedge clk_sys) begin
      if (wen) begin
         mem_r[wi0] <= bus.dq[15:0];
         mem_r[wi1] <= bus.dq[31:16];
      end
   end

   assign bus.dev_dq_o = dq_r;
   assign bus.dev_dq_oe = dq_oe_r;
   assign bus.dev_dqs_o = dq_oe_r;
   assign bus.dev_dqs_oe = dq_oe_r;
   assign bus.dev_dqs_n_o = 1'b0;
   assign bus.dev_dqs_n_oe = dq_oe_r & diff_r;
   assign self_refresh = st_r == ddrsr_pkg::D_SELF;
   assign term_on = term_r;
   assign cmd_error = err_r;
   assign strobe_diff = diff_r;
   assign read_latency = rlat;
   assign write_latency = rlat - 4'h1;
endmodule : ddrsr_dev

// file: dv/ddrsr_checker.sv
// Link checker: latency, burst, spacing and self refresh timing
`include "ddrsr_defs.svh"
module ddrsr_checker (
   input wire logic clk_sys,
   input wire logic rst,
   input wire ddrsr_pkg::ddrsr_cmd_t cmd,
   input wire logic on_die_termination,
   input wire logic ctl_dq_oe,
   input wire logic dev_dq_oe,
   input wire logic dev_dqs_oe,
   input wire logic dev_dqs_n_oe
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] exit_cnt_r;
   logic [7:0] exit_cnt_nxt;
   // ----
   // Cycles since exit; saturates so old exits never matter
   // ----
   always_comb begin
      exit_cnt_nxt = exit_cnt_r;
      if (cmd == ddrsr_pkg::CMD_SR_EXIT) begin
         exit_cnt_nxt = 8'h01;
      end else if (exit_cnt_r != 8'hff) begin
         exit_cnt_nxt = exit_cnt_r + 8'h01;
      end
   end
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         exit_cnt_r <= 8'hff;
      end else begin
         exit_cnt_r <= exit_cnt_nxt;
      end
   end
   // ----
   // Assertions
   // ----
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   rd_latency_a: assert property (cmd == ddrsr_pkg::CMD_RD |-> ##5 dev_dq_oe [*2])
      else $error("read data late or short");
   wr_latency_a: assert property (cmd == ddrsr_pkg::CMD_WR |-> ##4 ctl_dq_oe [*2])
      else $error("write data late or short");
   rd_gap_a: assert property (cmd == ddrsr_pkg::CMD_RD |=> !(cmd inside {ddrsr_pkg::CMD_RD, ddrsr_pkg::CMD_WR}))
      else $error("read followed too closely");
   wr_gap_a: assert property (cmd == ddrsr_pkg::CMD_WR |=> !(cmd inside {ddrsr_pkg::CMD_RD, ddrsr_pkg::CMD_WR}))
      else $error("write followed too closely");
   odt_entry_a: assert property (cmd == ddrsr_pkg::CMD_SR_ENTER |->
      !on_die_termination && !$past(on_die_termination) && !$past(on_die_termination, 2)
      && !$past(on_die_termination, 3))
      else $error("termination not off before entry");
   odt_exit_a: assert property (on_die_termination |-> exit_cnt_r >= `DDRSR_XRD_CYC)
      else $error("termination back too early");
   exit_read_a: assert property (cmd == ddrsr_pkg::CMD_RD |-> exit_cnt_r >= `DDRSR_XRD_CYC)
      else $error("read too soon after exit");
   exit_other_a: assert property (!(cmd inside {ddrsr_pkg::CMD_NOP, ddrsr_pkg::CMD_RD, ddrsr_pkg::CMD_SR_EXIT})
      |-> exit_cnt_r >= `DDRSR_XNR_CYC)
      else $error("command too soon after exit");
   strobe_pair_a: assert property (dev_dq_oe |-> dev_dqs_oe && dev_dqs_n_oe)
      else $error("read strobe pair missing");
   cover property (cmd == ddrsr_pkg::CMD_RD ##2 cmd == ddrsr_pkg::CMD_RD);
   cover property (cmd == ddrsr_pkg::CMD_SR_ENTER);
   cover property (cmd == ddrsr_pkg::CMD_SR_EXIT);
endmodule : ddrsr_checker

// file: dv/ddrsr_tb.sv
// Testbench joining controller and device ends over the link
module ddrsr_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic req_valid = 1'b0;
   logic req_write = 1'b0;
   logic [1:0] req_bank = 2'h0;
   logic [9:0] req_col = 10'h000;
   logic [127:0] req_wdata = 128'h0;
   logic sr_req = 1'b0;
   logic term_req = 1'b0;
   logic req_ready, rd_valid, sr_active, self_refresh, term_on, cmd_error, strobe_diff;
   logic [127:0] rd_data;
   logic [3:0] read_latency, write_latency;
   int fails = 0;
   int total_checks = 0;
   int cmd_errs = 0;
   localparam logic [63:0] D0 = 64'h0123_4567_89ab_cdef;
   localparam logic [63:0] D1 = 64'hfedc_ba98_7654_3210;
   always #10 clk_sys = ~clk_sys;
   ddrsr_if link ();
   ddrsr_ctl u_ddrsr_ctl (.clk_sys(clk_sys), .rst(rst), .bus(link.ctl), .req_valid(req_valid),
      .req_write(req_write), .req_bank(req_bank), .req_row(13'h0005), .req_col(req_col),
      .req_wdata(req_wdata), .req_ready(req_ready), .rd_valid(rd_valid), .rd_data(rd_data),
      .sr_req(sr_req), .sr_active(sr_active), .term_req(term_req));
   ddrsr_dev u_ddrsr_dev (.clk_sys(clk_sys), .rst(rst), .bus(link.dev), .self_refresh(self_refresh),
      .term_on(term_on), .cmd_error(cmd_error), .strobe_diff(strobe_diff),
      .read_latency(read_latency), .write_latency(write_latency));
   ddrsr_checker u_ddrsr_checker (.clk_sys(clk_sys), .rst(rst), .cmd(link.cmd),
      .on_die_termination(link.on_die_termination), .ctl_dq_oe(link.ctl_dq_oe),
      .dev_dq_oe(link.dev_dq_oe), .dev_dqs_oe(link.dev_dqs_oe), .dev_dqs_n_oe(link.dev_dqs_n_oe));
   always @(posedge clk_sys) begin
      if (cmd_error === 1'b1) begin
         cmd_errs <= cmd_errs + 1;
      end
   end
   // ----
   // Tasks
   // ----
   task automatic check(input logic [63:0] got, input logic [63:0] exp);
      total_checks++;
      if (got !== exp) begin
         fails++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : give_verdict
   // Bounded wait step; exit delays need room for 200 cycles
   task automatic tick(inout int n);
      @(negedge clk_sys);
      n++;
      if (n > 400) begin
         fails++;
         give_verdict();
      end
   endtask : tick
   // Entered at a rising edge; leaves at the edge that takes it
   task automatic request(input logic wr, input logic [1:0] bk, input logic [9:0] col, input logic [63:0] data);
      int n;
      n = 0;
      req_valid <= 1'b1;
      req_write <= wr;
      req_bank <= bk;
      req_col <= col;
      req_wdata <= {64'h0, data};
      do tick(n); while (req_ready !== 1'b1);
      @(posedge clk_sys);
   endtask : request
   task automatic expect_read(input logic [63:0] exp);
      int n;
      n = 0;
      do tick(n); while (rd_valid !== 1'b1);
      check(rd_data[63:0], exp);
      // Hand back on a rising edge so the next drive lands on the clock
      @(posedge clk_sys);
   endtask : expect_read
   initial begin
      int n;
      n = 0;
      repeat (2) @(posedge clk_sys);
      rst <= 1'b0;
      term_req <= 1'b1;
      repeat (4) @(posedge clk_sys);
      check(read_latency, 64'h5);
      check(write_latency, 64'h4);
      check(strobe_diff, 64'h1);
      request(1'b1, 2'h0, 10'h000, D0);
      request(1'b1, 2'h1, 10'h004, D1);
      request(1'b0, 2'h0, 10'h000, 64'h0);
      request(1'b0, 2'h1, 10'h004, 64'h0);
      req_valid <= 1'b0;
      expect_read(D0);
      expect_read(D1);
      request(1'b0, 2'h0, 10'h002, 64'h0);
      req_valid <= 1'b0;
      expect_read({D0[31:0], D0[63:32]});
      sr_req <= 1'b1;
      do tick(n); while (sr_active !== 1'b1);
      repeat (2) @(negedge clk_sys);
      check(self_refresh, 64'h1);
      check(link.on_die_termination, 64'h0);
      check(term_on, 64'h0);
      @(posedge clk_sys);
      sr_req <= 1'b0;
      request(1'b0, 2'h1, 10'h004, 64'h0);
      req_valid <= 1'b0;
      expect_read(D1);
      @(negedge clk_sys);
      check(term_on, 64'h1);
      check(cmd_errs, 64'h0);
      give_verdict();
   end
endmodule : ddrsr_tb
